// file: include/rpsm_pkg.sv
// Constants and types for the remappable pin select map
package rpsm_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int SEL_W = 6;
    localparam int NUM_PINS = 64;
    localparam int NUM_IN = 19;
    localparam int NUM_OUT_PINS = 6;
    localparam int NUM_FIELDS = 26;
    localparam int NUM_REGS = 13;
    localparam int HOLE_FIELD = 19;
    localparam int OUT_FIELD0 = 20;

    // ----------------------------------------
    // Field positions inside a register
    // ----------------------------------------
    localparam int LO_LSB = 0;
    localparam int HI_LSB = 8;

    // ----------------------------------------
    // Register byte offsets (word index times four)
    // ----------------------------------------
    localparam logic [11:0] UART1_INPUT_MAP_OFS = 12'h000;
    localparam logic [11:0] UART2_INPUT_MAP_OFS = 12'h004;
    localparam logic [11:0] SPI1_CLK_DATA_INPUT_MAP_OFS = 12'h008;
    localparam logic [11:0] UART3_CTS_SPI1_SEL_INPUT_MAP_OFS = 12'h00c;
    localparam logic [11:0] SPI2_CLK_DATA_INPUT_MAP_OFS = 12'h010;
    localparam logic [11:0] TIMER_CLK_SPI2_SEL_INPUT_MAP_OFS = 12'h014;
    localparam logic [11:0] LOGIC_CELL_INPUT_MAP_OFS = 12'h018;
    localparam logic [11:0] UART4_INPUT_MAP_OFS = 12'h01c;
    localparam logic [11:0] SPI3_CLK_DATA_INPUT_MAP_OFS = 12'h020;
    localparam logic [11:0] SPI3_SEL_INPUT_MAP_OFS = 12'h024;
    localparam logic [11:0] OUTPUT_MAP_PINS_0_1_OFS = 12'h028;
    localparam logic [11:0] OUTPUT_MAP_PINS_2_3_OFS = 12'h02c;
    localparam logic [11:0] OUTPUT_MAP_PINS_4_5_OFS = 12'h030;

    // ----------------------------------------
    // Reset values of the select fields
    // ----------------------------------------
    localparam logic [5:0] IN_SEL_RST = 6'h3f;
    localparam logic [5:0] OUT_SEL_RST = 6'h00;
    localparam logic [5:0] NO_DRIVE_SEL = 6'h00;

    // ----------------------------------------
    // Bit positions of peripheral inputs
    // ----------------------------------------
    localparam int UART1_RECEIVE = 0;
    localparam int UART1_CTS = 1;
    localparam int UART2_RECEIVE = 2;
    localparam int UART2_CTS = 3;
    localparam int SPI1_DATA_IN = 4;
    localparam int SPI1_CLOCK_IN = 5;
    localparam int SPI1_SLAVE_SEL = 6;
    localparam int UART3_CTS = 7;
    localparam int SPI2_DATA_IN = 8;
    localparam int SPI2_CLOCK_IN = 9;
    localparam int SPI2_SLAVE_SEL = 10;
    localparam int TIMER_EXTERNAL_CLOCK = 11;
    localparam int LOGIC_CELL_IN_A = 12;
    localparam int LOGIC_CELL_IN_B = 13;
    localparam int UART4_RECEIVE = 14;
    localparam int UART4_CTS = 15;
    localparam int SPI3_DATA_IN = 16;
    localparam int SPI3_CLOCK_IN = 17;
    localparam int SPI3_SLAVE_SEL = 18;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } rpsm_apb_req_t;

    typedef struct packed {
        logic [NUM_FIELDS-1:0][SEL_W-1:0] fld;
        logic [NUM_PINS-1:0] pin_meta;
        logic [NUM_PINS-1:0] pin_sync;
        logic [NUM_IN-1:0] periph_in;
        logic [NUM_OUT_PINS-1:0] rp_out;
        logic [NUM_OUT_PINS-1:0] rp_oe;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rpsm_state_t;

endpackage

// file: rtl/rpsm_map.sv
// Remappable pin select map: APB registers, input and output routing
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/10ps
module rpsm_map #(
    parameter bit PIN5_PRESENT = 1'b1
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Remappable pins, asynchronous to pclk
    input wire logic [rpsm_pkg::NUM_PINS-1:0] rp_in,
    output logic [rpsm_pkg::NUM_OUT_PINS-1:0] rp_out,
    output logic [rpsm_pkg::NUM_OUT_PINS-1:0] rp_oe,
    // On-chip peripherals
    input wire logic [rpsm_pkg::NUM_PINS-1:0] periph_out,
    output logic [rpsm_pkg::NUM_IN-1:0] periph_in
);
    import rpsm_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    rpsm_state_t st_reg;
    rpsm_state_t st_next;
    rpsm_apb_req_t req;
    logic [3:0] widx;
    logic hit;

    // Bundle the bus request for the decode below
    assign req = '{psel, penable, pwrite, paddr, pwdata};

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        widx = req.paddr[5:2];
        // Only aligned words inside the thirteen-word window are mapped
        hit = (req.paddr[11:6] == 6'h00) && (req.paddr[1:0] == 2'h0) &&
              (widx < 4'(NUM_REGS));

        // Two-flop pin synchroniser; stage one feeds stage two only
        st_next.pin_meta = rp_in;
        st_next.pin_sync = st_reg.pin_meta;

        // Zero-wait APB: ready is raised for exactly the access cycle
        // Read data returns to zero outside the access cycle of a read
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        st_next.prdata = 32'h0000_0000;
        if (req.psel && !req.penable) begin
            st_next.pready = 1'b1;
            st_next.pslverr = !hit;
            if (hit && !req.pwrite) begin
                // Unused bits always return zero
                st_next.prdata[HI_LSB +: SEL_W] =
                    st_reg.fld[{widx, 1'b1}];
                st_next.prdata[LO_LSB +: SEL_W] =
                    st_reg.fld[{widx, 1'b0}];
            end
        end

        // Writes take effect at the completing edge of the access
        if (req.psel && req.penable && st_reg.pready && req.pwrite &&
            !st_reg.pslverr) begin
            // Low field of register w is field 2w, high field 2w+1
            st_next.fld[{widx, 1'b0}] =
                req.pwdata[LO_LSB +: SEL_W];
            // The upper half of the last input register is not storage
            if ({widx, 1'b1} != 5'(HOLE_FIELD)) begin
                st_next.fld[{widx, 1'b1}] =
                    req.pwdata[HI_LSB +: SEL_W];
            end
        end

        // Input routing from the synchronised pins; a stale selection is
        // visible for one cycle after a write, never longer
        for (int i = 0; i < NUM_IN; i++) begin
            st_next.periph_in[i] = st_reg.pin_sync[st_reg.fld[i]];
        end

        // Output routing; select zero means the pin is not driven
        for (int p = 0; p < NUM_OUT_PINS; p++) begin
            st_next.rp_out[p] =
                periph_out[st_reg.fld[OUT_FIELD0 + p]];
            st_next.rp_oe[p] =
                (st_reg.fld[OUT_FIELD0 + p] != NO_DRIVE_SEL);
        end
        // Pin 5 is bonded out only on the larger packages
        if (!PIN5_PRESENT) begin
            st_next.rp_oe[NUM_OUT_PINS-1] = 1'b0;
            st_next.rp_out[NUM_OUT_PINS-1] = 1'b0;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            for (int f = 0; f < NUM_FIELDS; f++) begin
                if (f < HOLE_FIELD) begin
                    st_reg.fld[f] <= IN_SEL_RST;
                end else begin
                    st_reg.fld[f] <= OUT_SEL_RST;
                end
            end
        end else begin
            st_reg <= st_next;
        end
    end

    // Every output comes straight from the state register
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign rp_out = st_reg.rp_out;
    assign rp_oe = st_reg.rp_oe;
    assign periph_in = st_reg.periph_in;

endmodule

// file: tb/rpsm_map_props.sv
// Port checker for the remappable pin select map
`timescale 1ns/10ps
module rpsm_map_props #(
    parameter bit PIN5_PRESENT = 1'b1
) (
    // APB slave side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and peripherals
    input wire logic [63:0] rp_in,
    input wire logic [5:0] rp_out,
    input wire logic [5:0] rp_oe,
    input wire logic [63:0] periph_out,
    input wire logic [18:0] periph_in
);
    import rpsm_pkg::*;
    // ----------------------------------------
    // Shadow of the watched fields
    // ----------------------------------------
    logic [5:0] is0_reg;
    logic [5:0] os_reg [6];
    logic [63:0] d1_reg;
    logic [63:0] d2_reg;
    logic [5:0] eoe;
    logic wr;
    assign wr = psel && penable && pready && pwrite;
    // Updated on the same edge that stores the write in the design
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            is0_reg <= IN_SEL_RST;
            os_reg <= '{default: OUT_SEL_RST};
            d1_reg <= '0;
            d2_reg <= '0;
        end else begin
            d1_reg <= rp_in;
            d2_reg <= d1_reg;
            if (wr && paddr == UART1_INPUT_MAP_OFS)
                is0_reg <= pwdata[5:0];
            for (int i = 0; i < 6; i++)
                if (wr && paddr == OUTPUT_MAP_PINS_0_1_OFS + 12'(4 * (i / 2)))
                    os_reg[i] <= pwdata[8 * (i % 2) +: 6];
        end
    end
    // Pin 5 stays quiet on parts that lack it
    always_comb
        for (int i = 0; i < 6; i++)
            eoe[i] = os_reg[i] != 6'h00 && (i < 5 || PIN5_PRESENT);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s; psel && !penable; endsequence
    sequence rd_s; pready && !pwrite; endsequence
    a_access_next: assert property (setup_s |=> penable && pready)
        else $error("setup not answered in the next cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_unused_zero: assert property (rd_s |->
        prdata[31:14] == 18'h0 && prdata[7:6] == 2'h0)
        else $error("unused read bits not zero");
    a_narrow_reg: assert property (
        rd_s ##0 paddr == SPI3_SEL_INPUT_MAP_OFS |-> prdata[15:6] == 10'h0)
        else $error("upper bits of slave select map not zero");
    a_unmapped_err: assert property (
        pready && paddr > 12'h030 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_oe_follow: assert property (rp_oe == $past(eoe))
        else $error("pin enables do not follow selections");
    a_out_route: assert property ($past(presetn) |->
        {rp_out[4], rp_out[0]} ==
        $past({periph_out[os_reg[4]], periph_out[os_reg[0]]}))
        else $error("pin drive not the selected output");
    a_in_route: assert property (
        periph_in[UART1_RECEIVE] == $past(d2_reg[is0_reg]))
        else $error("receive input not the selected pin");
endmodule
bind rpsm_map rpsm_map_props #(.PIN5_PRESENT(PIN5_PRESENT)) i_props (.*);

// file: tb/rpsm_pins.sv
// Peripherals and pins around the select map
`timescale 1ns/10ps
module rpsm_pins (
    // Clock
    input wire logic pclk,
    // Pin levels and peripheral outputs
    output logic [rpsm_pkg::NUM_PINS-1:0] rp_in = 64'h0,
    output logic [rpsm_pkg::NUM_PINS-1:0] periph_out = 64'h0
);
    import rpsm_pkg::*;
    int seed = 76;
    // New levels every cycle, so a stale route cannot match by luck
    always @(posedge pclk) begin
        rp_in <= {$random(seed), $random(seed)};
        periph_out <= {$random(seed), $random(seed)};
    end
endmodule

// file: tb/remappable_pin_select_map_tb.sv
// Self-checking bench for the remappable pin select map
`timescale 1ns/10ps
module remappable_pin_select_map_tb;
    import rpsm_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, d;
    logic [63:0] rp_in, periph_out, h1, h2, h3, p1;
    logic [5:0] rp_out, rp_oe;
    logic [18:0] periph_in;
    logic err;
    // Second copy built for the package that lacks pin 5
    logic [31:0] prdata5;
    logic pready5, pslverr5;
    logic [5:0] rp_out5, rp_oe5;
    logic [18:0] periph_in5;
    logic [15:0] mdl [13];
    int n_fail = 0, n_checks = 0, seed = 76, cyc = 0;
    always #4 pclk = ~pclk;
    rpsm_pins i_pins (.*);
    rpsm_map i_dut (.*);
    rpsm_map #(.PIN5_PRESENT(1'b0)) i_dut_small (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata5),
        .pready(pready5),
        .pslverr(pslverr5),
        .rp_in(rp_in),
        .rp_out(rp_out5),
        .rp_oe(rp_oe5),
        .periph_out(periph_out),
        .periph_in(periph_in5)
    );
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic acc(logic w, logic [11:0] a, logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] msk(int i);
        return i == 9 ? 32'h3f : 32'h3f3f;
    endfunction
    function automatic logic [5:0] fld(int r, int h);
        return 6'(mdl[r] >> (8 * h));
    endfunction
    task automatic give_verdict();
        if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Pin history for the three-cycle input path; hang guard
    always @(posedge pclk) begin
        h1 <= rp_in;
        h2 <= h1;
        h3 <= h2;
        p1 <= periph_out;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            give_verdict();
        end
    end
    // Reset values first, then all ones, then random words
    initial begin
        for (int i = 0; i < 13; i++) mdl[i] = i < 10 ? 16'(msk(i)) : 16'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 13; i++) begin
                d = k == 1 ? 32'hffffffff : $random(seed);
                if (k > 0) acc(1'b1, 12'(4 * i), d);
                if (k > 0) mdl[i] = 16'(d & msk(i));
                acc(1'b0, 12'(4 * i), 32'h0);
                chk("register", rd, {16'h0, mdl[i]});
            end
            acc(1'b1, 12'h034, 32'hffffffff);
            chk("error", {31'h0, err}, 32'h1);
            repeat (4) @(posedge pclk);
            repeat (40) begin
                @(negedge pclk);
                for (int b = 0; b < 19; b++) chk("input", periph_in[b], h3[fld(b / 2, b % 2)]);
                for (int p = 0; p < 6; p++) begin
                    chk("drive", rp_out[p], p1[fld(10 + p / 2, p % 2)]);
                    chk("enable", rp_oe[p], fld(10 + p / 2, p % 2) != 6'h00);
                    chk("small enable", rp_oe5[p],
                        p < 5 && fld(10 + p / 2, p % 2) != 6'h00);
                    chk("small drive", rp_out5[p],
                        p < 5 && p1[fld(10 + p / 2, p % 2)]);
                end
            end
        end
        give_verdict();
    end
endmodule
